// File: hdl/cal_corrector.sv
// Purpose: Gain and offset correction of one converted monitor result
// Assumes: Gain is unsigned fixed point with CAL_FRAC_BITS fraction bits
// Notes:   Result saturates to the converter range; one cycle latency
module cal_corrector #(
	parameter int RESULT_W = monitor_pkg::RESULT_W
)(
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic                cal_enable,
	input  wire logic [15:0]         gain,
	input  wire logic [15:0]         offset,
	input  wire logic [RESULT_W-1:0] raw,
	input  wire logic                raw_valid,
	output logic      [RESULT_W-1:0] result,
	output logic                     result_valid
);
	localparam logic signed [31:0] MAX_VAL = 32'((1 << RESULT_W) - 1);

	logic signed [31:0]   product;
	logic signed [31:0]   sum;
	logic [RESULT_W-1:0]  next_result;
	logic                 next_valid;

	always_comb
	begin
		product = $signed({1'b0, 15'h0000, gain}) * $signed({20'h00000, raw});
		sum = (product >>> monitor_pkg::CAL_FRAC_BITS) + 32'(signed'(offset));
		next_result = result;
		next_valid = raw_valid;
		if (raw_valid)
		begin
			if (!cal_enable)
				next_result = raw;
			else if (sum < 0)
				next_result = '0;
			else if (sum > MAX_VAL)
				next_result = MAX_VAL[RESULT_W-1:0];
			else
				next_result = sum[RESULT_W-1:0]; // R11
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			result <= '0;
			result_valid <= 1'b0;
		end
		else
		begin
			result <= next_result;
			result_valid <= next_valid;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	cal_pass_raw_a: assert property (raw_valid && !cal_enable |=> result_valid && result == $past(raw)) // R11
		else $error("uncorrected result not passed through");
	cal_unity_a: assert property (raw_valid && cal_enable && gain == 16'h4000 && offset == 16'h0000
		|=> result == $past(raw)) // R11
		else $error("unity calibration altered result");

endmodule : cal_corrector

// File: hdl/current_monitor_phase_sequencer.sv
// Purpose: Switch sequencer, controls and result correction for one current monitor
// Assumes: AXI4-Lite master, one write and one read outstanding at most
// Notes:   Software holds the strobe; the converter start is outside this block
//
// How it works
// (R1) An asserted strobe moves the idle sequencer into the switch sequence.
// (R2) Strobe removal or a cleared enable returns to idle from any phase; nothing else aborts.
// (R3) Idle closes switches one to three and opens switch four.
// (R4) Sample phase opens switches one and two, keeps three closed.
// (R5) Gap phase opens all four switches between sample and track.
// (R6) Track closes only switch four and holds while the strobe stays high.
// (R7) Phases advance idle, sample, gap, track; idle again only on strobe removal or a cleared enable.
// (R8) A run-time enable per monitor; cleared puts the monitor in low power.
// (R9) Bypass select steers the converter channel to amplifier or high side pad.
// (R10) Direct-input setting opens or closes the isolation switch.
// (R11) Converted results get gain and offset correction by default.
// (R12) Regular and global strobes are ORed into the effective strobe.
// (R13) Controller waits 1 us after the strobe before starting a conversion.
// (R14) Controller keeps the strobe until the converter goes from sample to hold.
// (R15) Controller holds the strobe 5 to 200 us high, at least 5 us low.
// (R16) Sample and gap phase lengths are fixed cycle counts set by parameters.
// (R17) A cleared enable forces idle and ignores strobes until set again.
module current_monitor_phase_sequencer #(
	parameter int          SAMPLE_CYCLES      = monitor_pkg::SAMPLE_CYCLES,
	parameter int          GAP_CYCLES         = monitor_pkg::GAP_CYCLES,
	parameter logic [15:0] CAL_GAIN_DEFAULT   = monitor_pkg::CAL_GAIN_RESET,
	parameter logic [15:0] CAL_OFFSET_DEFAULT = monitor_pkg::CAL_OFFSET_RESET
)(
	input  wire logic                             aclk,
	input  wire logic                             aresetn,
	input  wire logic [monitor_pkg::ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                             s_axi_awvalid,
	output logic                                  s_axi_awready,
	input  wire logic [31:0]                      s_axi_wdata,
	input  wire logic [3:0]                       s_axi_wstrb,
	input  wire logic                             s_axi_wvalid,
	output logic                                  s_axi_wready,
	output logic [1:0]                            s_axi_bresp,
	output logic                                  s_axi_bvalid,
	input  wire logic                             s_axi_bready,
	input  wire logic [monitor_pkg::ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                             s_axi_arvalid,
	output logic                                  s_axi_arready,
	output logic [31:0]                           s_axi_rdata,
	output logic [1:0]                            s_axi_rresp,
	output logic                                  s_axi_rvalid,
	input  wire logic                             s_axi_rready,
	input  wire logic [monitor_pkg::RESULT_W-1:0] adc_result,
	input  wire logic                             adc_result_valid,
	output logic [monitor_pkg::RESULT_W-1:0]      corrected_result,
	output logic                                  corrected_valid,
	output monitor_pkg::switch_set_s              switches,
	output logic                                  isolation_switch,
	output logic                                  bypass_select,
	output logic                                  monitor_power_enable
);
	localparam int TW = monitor_pkg::TIMER_W;

	monitor_pkg::ctrl_s                  ctrl;
	monitor_pkg::ctrl_s                  next_ctrl;
	logic                                global_strobe;
	logic                                next_global_strobe;
	logic [15:0]                         cal_gain;
	logic [15:0]                         next_cal_gain;
	logic [15:0]                         cal_offset;
	logic [15:0]                         next_cal_offset;
	logic [monitor_pkg::ADDR_W-1:0]      aw_addr;
	logic [monitor_pkg::ADDR_W-1:0]      next_aw_addr;
	logic [31:0]                         w_data;
	logic [31:0]                         next_w_data;
	logic [3:0]                          w_strb;
	logic [3:0]                          next_w_strb;
	logic                                next_awready;
	logic                                next_wready;
	logic                                next_bvalid;
	logic [1:0]                          next_bresp;
	logic                                next_arready;
	logic                                next_rvalid;
	logic [31:0]                         next_rdata;
	logic [1:0]                          next_rresp;
	logic                                do_write;
	monitor_pkg::phase_e                 phase;
	monitor_pkg::phase_e                 next_phase;
	logic [TW-1:0]                       timer;
	logic [TW-1:0]                       next_timer;
	monitor_pkg::switch_set_s            next_switches;
	logic                                eff_strobe;

	// Either source starts the sequence; both must be low to end it
	assign eff_strobe = ctrl.strobe | global_strobe; // R12

	// Register slave: write side
	always_comb
	begin
		next_awready = s_axi_awready;
		next_wready = s_axi_wready;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_ctrl = ctrl;
		next_global_strobe = global_strobe;
		next_cal_gain = cal_gain;
		next_cal_offset = cal_offset;
		do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
		if (s_axi_bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_addr = s_axi_awaddr;
			next_awready = 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
			next_wready = 1'b0;
		end
		if (do_write)
		begin
			next_bvalid = 1'b1;
			next_awready = 1'b1;
			next_wready = 1'b1;
			next_bresp = monitor_pkg::RESP_OKAY;
			unique case (aw_addr[monitor_pkg::ADDR_W-1:2])
				monitor_pkg::CTRL_OFFSET[monitor_pkg::ADDR_W-1:2]:
					if (w_strb[0])
						next_ctrl = w_data[4:0]; // R8 R9 R10
				monitor_pkg::GSTROBE_OFFSET[monitor_pkg::ADDR_W-1:2]:
					if (w_strb[0])
						next_global_strobe = w_data[0];
				monitor_pkg::CAL_GAIN_OFFSET[monitor_pkg::ADDR_W-1:2]:
				begin
					if (w_strb[0])
						next_cal_gain[7:0] = w_data[7:0];
					if (w_strb[1])
						next_cal_gain[15:8] = w_data[15:8];
				end
				monitor_pkg::CAL_OFFSET_OFFSET[monitor_pkg::ADDR_W-1:2]:
				begin
					if (w_strb[0])
						next_cal_offset[7:0] = w_data[7:0];
					if (w_strb[1])
						next_cal_offset[15:8] = w_data[15:8];
				end
				// Status and result are read-only; writes are dropped quietly
				monitor_pkg::STATUS_OFFSET[monitor_pkg::ADDR_W-1:2],
				monitor_pkg::RESULT_OFFSET[monitor_pkg::ADDR_W-1:2]: ;
				default:
					next_bresp = monitor_pkg::RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= monitor_pkg::RESP_OKAY;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			ctrl <= monitor_pkg::CTRL_RESET;
			global_strobe <= 1'b0;
			cal_gain <= CAL_GAIN_DEFAULT;
			cal_offset <= CAL_OFFSET_DEFAULT;
		end
		else
		begin
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			ctrl <= next_ctrl;
			global_strobe <= next_global_strobe;
			cal_gain <= next_cal_gain;
			cal_offset <= next_cal_offset;
		end
	end

	// Register slave: read side
	always_comb
	begin
		next_arready = s_axi_arready;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready)
		begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_rvalid = 1'b1;
			next_arready = 1'b0;
			next_rresp = monitor_pkg::RESP_OKAY;
			next_rdata = 32'h00000000;
			unique case (s_axi_araddr[monitor_pkg::ADDR_W-1:2])
				monitor_pkg::CTRL_OFFSET[monitor_pkg::ADDR_W-1:2]:
					next_rdata = {27'h0000000, ctrl};
				monitor_pkg::GSTROBE_OFFSET[monitor_pkg::ADDR_W-1:2]:
					next_rdata = {31'h00000000, global_strobe};
				monitor_pkg::STATUS_OFFSET[monitor_pkg::ADDR_W-1:2]:
					next_rdata = {24'h000000, switches, eff_strobe, 1'b0,
						monitor_pkg::phase_code(phase)};
				monitor_pkg::CAL_GAIN_OFFSET[monitor_pkg::ADDR_W-1:2]:
					next_rdata = {16'h0000, cal_gain};
				monitor_pkg::CAL_OFFSET_OFFSET[monitor_pkg::ADDR_W-1:2]:
					next_rdata = {16'h0000, cal_offset};
				monitor_pkg::RESULT_OFFSET[monitor_pkg::ADDR_W-1:2]:
					next_rdata = {20'h00000, corrected_result};
				default:
					next_rresp = monitor_pkg::RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= monitor_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	// Phase sequencer; switch outputs follow the next phase so they stay registered
	always_comb
	begin
		next_phase = phase;
		next_timer = timer;
		if (!ctrl.enable || !eff_strobe)
			next_phase = monitor_pkg::PH_IDLE; // R2 R17
		else
		begin
			unique case (phase)
				monitor_pkg::PH_IDLE:
				begin
					next_phase = monitor_pkg::PH_SAMPLE; // R1 R7
					next_timer = TW'(SAMPLE_CYCLES - 1); // R16
				end
				monitor_pkg::PH_SAMPLE:
					if (timer == '0)
					begin
						next_phase = monitor_pkg::PH_GAP; // R5 R7
						next_timer = TW'(GAP_CYCLES - 1); // R16
					end
					else
						next_timer = timer - 1'b1;
				monitor_pkg::PH_GAP:
					if (timer == '0)
						next_phase = monitor_pkg::PH_TRACK; // R7
					else
						next_timer = timer - 1'b1;
				monitor_pkg::PH_TRACK:
					next_phase = monitor_pkg::PH_TRACK; // R6
			endcase
		end
		next_switches = monitor_pkg::switch_pattern(next_phase); // R3 R4 R5 R6
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			phase <= monitor_pkg::PH_IDLE;
			timer <= '0;
			switches <= monitor_pkg::switch_pattern(monitor_pkg::PH_IDLE);
		end
		else
		begin
			phase <= next_phase;
			timer <= next_timer;
			switches <= next_switches;
		end
	end

	// Plain register bits drive the pad controls directly
	assign monitor_power_enable = ctrl.enable; // R8
	assign bypass_select = ctrl.bypass_select; // R9
	assign isolation_switch = ctrl.direct_input_switch_on; // R10

	cal_corrector #(
		.RESULT_W     (monitor_pkg::RESULT_W)
	) corrector (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.cal_enable   (!ctrl.cal_bypass), // R11
		.gain         (cal_gain),
		.offset       (cal_offset),
		.raw          (adc_result),
		.raw_valid    (adc_result_valid),
		.result       (corrected_result),
		.result_valid (corrected_valid)
	);

	// Checks
	logic [TW-1:0] phase_age;

	always_ff @(posedge aclk)
	begin
		if (!aresetn || phase != next_phase)
			phase_age <= '0;
		else if (phase_age != '1)
			phase_age <= phase_age + 1'b1;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	start_on_strobe_a: assert property (phase == monitor_pkg::PH_IDLE && ctrl.enable && eff_strobe
		|=> phase == monitor_pkg::PH_SAMPLE) // R1
		else $error("strobe did not start sequence");
	strobe_abort_a: assert property (!eff_strobe |=> phase == monitor_pkg::PH_IDLE) // R2
		else $error("strobe removal did not return to idle");
	idle_switches_a: assert property (phase == monitor_pkg::PH_IDLE
		|-> switches == 4'h7) // R3
		else $error("idle switch pattern wrong");
	sample_switches_a: assert property (phase == monitor_pkg::PH_SAMPLE
		|-> switches == 4'h4) // R4
		else $error("sample switch pattern wrong");
	gap_break_a: assert property (phase == monitor_pkg::PH_SAMPLE ##1 phase == monitor_pkg::PH_TRACK
		|-> 1'b0) // R5
		else $error("track entered without gap");
	track_hold_a: assert property (phase == monitor_pkg::PH_TRACK && ctrl.enable && eff_strobe
		|=> phase == monitor_pkg::PH_TRACK && switches == 4'h8) // R6
		else $error("track not held");
	phase_order_a: assert property (phase == monitor_pkg::PH_GAP
		|=> phase == monitor_pkg::PH_GAP || phase == monitor_pkg::PH_TRACK
			|| phase == monitor_pkg::PH_IDLE) // R7
		else $error("phase order broken");
	sample_length_a: assert property (phase == monitor_pkg::PH_SAMPLE
		&& next_phase == monitor_pkg::PH_GAP |-> phase_age == TW'(SAMPLE_CYCLES - 1)) // R16
		else $error("sample phase length wrong");
	// Power enable is checked in the same cycle, since software may set it at the next edge
	disable_idle_a: assert property (!ctrl.enable
		|-> !monitor_power_enable ##1 phase == monitor_pkg::PH_IDLE) // R8 R17
		else $error("disabled monitor not idle");
	global_strobe_a: assert property (phase == monitor_pkg::PH_IDLE && ctrl.enable && global_strobe
		&& !ctrl.strobe |=> phase == monitor_pkg::PH_SAMPLE) // R12
		else $error("global strobe ignored");
	bypass_follow_a: assert property (do_write && aw_addr[7:2] == 6'h00 && w_strb[0]
		|=> bypass_select == $past(w_data[2]) && isolation_switch == $past(w_data[3])) // R9 R10
		else $error("bypass or isolation not updated");

	reach_track_c: cover property (phase == monitor_pkg::PH_GAP ##1 phase == monitor_pkg::PH_TRACK);
	abort_sample_c: cover property (phase == monitor_pkg::PH_SAMPLE ##1 phase == monitor_pkg::PH_IDLE);
	global_start_c: cover property (global_strobe && !ctrl.strobe && phase == monitor_pkg::PH_TRACK);
	write_done_c: cover property (s_axi_bvalid && s_axi_bready);

endmodule : current_monitor_phase_sequencer

// File: hdl/monitor_pkg.sv
// Purpose: Shared constants, types and switch map for the current monitor sequencer
// Assumes: 10 MHz aclk, AXI4-Lite register access, 32-bit data
// Notes:   Phase timings are least times, rounded up to whole cycles
package monitor_pkg;

	localparam int CLK_PERIOD_NS  = 100;
	localparam int SAMPLE_TIME_NS = 400;
	localparam int GAP_TIME_NS    = 100;
	localparam int SAMPLE_CYCLES_RAW = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAP_CYCLES_RAW    = (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SAMPLE_CYCLES = (SAMPLE_CYCLES_RAW < 1) ? 1 : SAMPLE_CYCLES_RAW;
	localparam int GAP_CYCLES    = (GAP_CYCLES_RAW < 1) ? 1 : GAP_CYCLES_RAW;
	localparam int TIMER_W       = 8;

	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] CTRL_OFFSET       = 8'h00;
	localparam logic [ADDR_W-1:0] GSTROBE_OFFSET    = 8'h04;
	localparam logic [ADDR_W-1:0] STATUS_OFFSET     = 8'h08;
	localparam logic [ADDR_W-1:0] CAL_GAIN_OFFSET   = 8'h0C;
	localparam logic [ADDR_W-1:0] CAL_OFFSET_OFFSET = 8'h10;
	localparam logic [ADDR_W-1:0] RESULT_OFFSET     = 8'h14;

	localparam logic [4:0]  CTRL_RESET       = 5'h00;
	localparam logic [15:0] CAL_GAIN_RESET   = 16'h4000;
	localparam logic [15:0] CAL_OFFSET_RESET = 16'h0000;
	localparam int          CAL_FRAC_BITS    = 14;
	localparam int          RESULT_W         = 12;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {PH_IDLE, PH_SAMPLE, PH_GAP, PH_TRACK} phase_e;

	typedef struct packed {
		logic cal_bypass;
		logic direct_input_switch_on;
		logic bypass_select;
		logic strobe;
		logic enable;
	} ctrl_s;

	typedef struct packed {
		logic switch_four;
		logic switch_three;
		logic switch_two;
		logic switch_one;
	} switch_set_s;

	// A set bit means the switch is closed
	function automatic switch_set_s switch_pattern(input phase_e p);
		switch_set_s s;
		s = '0;
		unique case (p)
			PH_IDLE:   s = '{switch_four: 1'b0, switch_three: 1'b1, switch_two: 1'b1, switch_one: 1'b1};
			PH_SAMPLE: s = '{switch_four: 1'b0, switch_three: 1'b1, switch_two: 1'b0, switch_one: 1'b0};
			PH_GAP:    s = '{switch_four: 1'b0, switch_three: 1'b0, switch_two: 1'b0, switch_one: 1'b0};
			PH_TRACK:  s = '{switch_four: 1'b1, switch_three: 1'b0, switch_two: 1'b0, switch_one: 1'b0};
		endcase
		return s;
	endfunction : switch_pattern

	function automatic logic [1:0] phase_code(input phase_e p);
		logic [1:0] c;
		c = 2'h0;
		unique case (p)
			PH_IDLE:   c = 2'h0;
			PH_SAMPLE: c = 2'h1;
			PH_GAP:    c = 2'h2;
			PH_TRACK:  c = 2'h3;
		endcase
		return c;
	endfunction : phase_code

endpackage : monitor_pkg

// File: sim/adc_model.sv
// Purpose: Converter model that samples for a while, then returns one code
// Assumes: start is a one-cycle request from the bench
// Notes:   Result bus shows junk whenever valid is low
module adc_model #(
	parameter int SAMPLE_LEN = 3
)(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        start,
	input  wire logic [11:0] code,
	output logic      [11:0] adc_result,
	output logic             adc_result_valid,
	output logic             sampling
);
	timeunit 1ns;
	timeprecision 1ns;
	int          cnt;
	logic [11:0] held;
	// Inverted code whenever valid is low so a stale read never matches
	assign adc_result = adc_result_valid ? held : ~held;
	always_ff @(posedge aclk)
	begin
		adc_result_valid <= 1'b0;
		if (!aresetn)
		begin
			cnt      <= 0;
			sampling <= 1'b0;
			held     <= 12'h000;
		end
		else if (start && !sampling)
		begin
			sampling <= 1'b1;
			cnt      <= SAMPLE_LEN;
			held     <= code;
		end
		else if (sampling)
		begin
			cnt <= cnt - 1;
			if (cnt == 1)
			begin
				sampling         <= 1'b0;
				adc_result_valid <= 1'b1;
			end
		end
	end
endmodule : adc_model

// File: sim/current_monitor_phase_sequencer_tb.sv
// Purpose: Self-checking bench for the monitor sequencer over AXI4-Lite
// Assumes: Shortened sample count and lengthened gap count, bench acts as controller
// Notes:   Phase order is captured from the switch outputs every edge
`define CHECK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module current_monitor_phase_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SC = 3;
	localparam int GC = 2;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, bresp_q, rresp_q;
	logic [31:0] rdata, rdata_q;
	logic [11:0] adc_result, corrected_result, code = 12'h000;
	logic        adc_result_valid, corrected_valid, sampling, start = 1'b0;
	logic        isolation_switch, bypass_select, monitor_power_enable;
	monitor_pkg::switch_set_s switches;
	int          mismatches = 0, check_count = 0, dwell = 0, valid_seen = 0;
	logic [3:0]  last_sw, seen_q[$];
	int          len_q[$];
	logic [3:0]  pat[4] = '{4'h4, 4'h0, 4'h8, 4'h7};

	current_monitor_phase_sequencer #(.SAMPLE_CYCLES(SC), .GAP_CYCLES(GC)) u_current_monitor_phase_sequencer (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .adc_result(adc_result),
		.adc_result_valid(adc_result_valid), .corrected_result(corrected_result),
		.corrected_valid(corrected_valid), .switches(switches), .isolation_switch(isolation_switch),
		.bypass_select(bypass_select), .monitor_power_enable(monitor_power_enable));
	adc_model u_adc_model (.aclk(aclk), .aresetn(aresetn), .start(start), .code(code),
		.adc_result(adc_result), .adc_result_valid(adc_result_valid), .sampling(sampling));

	initial
	begin
		forever #50 aclk = ~aclk;
	end
	// Pre-edge switch values; dwell of the previous pattern is logged on change
	always @(posedge aclk)
	begin
		if (switches !== last_sw)
		begin
			seen_q.push_back(switches);
			len_q.push_back(dwell);
			dwell = 1;
			last_sw = switches;
		end
		else dwell++;
		if (corrected_valid === 1'b1) valid_seen++;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bresp_q = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rdata_q = rdata; rresp_q = rresp;
		rready <= 1'b0;
	endtask : rd
	// Start a conversion and wait until the converter holds
	task automatic convert(input logic [11:0] c);
		@(posedge aclk);
		code <= c; start <= 1'b1;
		@(posedge aclk);
		start <= 1'b0;
		@(posedge aclk);
		while (sampling) @(posedge aclk);
		repeat (3) @(posedge aclk);
	endtask : convert
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : final_report

	initial
	begin
		#500000;
		mismatches++;
		final_report();
	end
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		`CHECK(switches, 4'h7)
		`CHECK(monitor_power_enable, 1'b0)
		rd(monitor_pkg::CAL_GAIN_OFFSET);
		`CHECK(rdata_q[15:0], 16'h4000)
		seen_q.delete(); len_q.delete();
		wr(monitor_pkg::CTRL_OFFSET, 32'h03);
		`CHECK(monitor_power_enable, 1'b1)
		repeat (10) @(posedge aclk);
		rd(monitor_pkg::STATUS_OFFSET);
		`CHECK(rdata_q[7:0], 8'h8B)
		convert(12'h123);
		repeat (45) @(posedge aclk);
		wr(monitor_pkg::CTRL_OFFSET, 32'h01);
		repeat (50) @(posedge aclk);
		`CHECK(corrected_result, 12'h123)
		wr(monitor_pkg::GSTROBE_OFFSET, 32'h1);
		repeat (60) @(posedge aclk);
		wr(monitor_pkg::CTRL_OFFSET, 32'h00);
		`CHECK(monitor_power_enable, 1'b0)
		repeat (20) @(posedge aclk);
		`CHECK(switches, 4'h7)
		wr(monitor_pkg::CTRL_OFFSET, 32'h01);
		repeat (60) @(posedge aclk);
		wr(monitor_pkg::GSTROBE_OFFSET, 32'h0);
		repeat (50) @(posedge aclk);
		`CHECK(seen_q.size(), 12)
		for (int i = 0; i < seen_q.size(); i++)
		begin
			`CHECK(seen_q[i], pat[i % 4])
			if (i % 4 == 1) `CHECK(len_q[i], SC)
			if (i % 4 == 2) `CHECK(len_q[i], GC)
		end
		for (int i = 0; i < 4; i++)
		begin
			wr(monitor_pkg::CTRL_OFFSET, {28'h0, i[1:0], 2'b01});
			`CHECK(isolation_switch, i[1])
			`CHECK(bypass_select, i[0])
		end
		wr(monitor_pkg::CAL_GAIN_OFFSET, 32'h2000);
		wr(monitor_pkg::CAL_OFFSET_OFFSET, 32'h5);
		convert(12'h100);
		`CHECK(corrected_result, 12'h085)
		wr(monitor_pkg::CAL_OFFSET_OFFSET, 32'hFFF0);
		convert(12'h010);
		`CHECK(corrected_result, 12'h000)
		wr(monitor_pkg::CTRL_OFFSET, 32'h10);
		convert(12'h100);
		rd(monitor_pkg::RESULT_OFFSET);
		`CHECK(rdata_q[11:0], 12'h100)
		rd(8'h40);
		`CHECK(rresp_q, monitor_pkg::RESP_SLVERR)
		wr(8'h44, 32'h1);
		`CHECK(bresp_q, monitor_pkg::RESP_SLVERR)
		`CHECK(valid_seen, 4)
		final_report();
	end
endmodule : current_monitor_phase_sequencer_tb
